// ### clock_buzzer_pkg.sv
package clock_buzzer_pkg;
    // Register byte addresses
    localparam logic [15:0] CKS_OFS = 16'hFF40;
    localparam logic [15:0] DIR_OFS = 16'hFF44;
    localparam logic [15:0] LATCH_OFS = 16'hFF48;
    localparam logic [15:0] CKS_SET_OFS = 16'hFF4C;
    localparam logic [15:0] CKS_CLR_OFS = 16'hFF50;
    // Reset values
    localparam logic [7:0] CKS_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hFF;
    localparam logic [7:0] LATCH_RST = 8'h00;
    // Field positions in clock_output_select
    localparam int BZ_EN_BIT = 7;
    localparam int BZ_SEL_HI = 6;
    localparam int BZ_SEL_LO = 5;
    localparam int CL_EN_BIT = 4;
    localparam int CL_SEL_HI = 3;
    localparam int CL_SEL_LO = 0;
    // Pin positions in direction and latch registers
    localparam int CLK_PIN_BIT = 0;
    localparam int BUZ_PIN_BIT = 1;
    // Divider settings: half period is 2**exp cycles
    localparam logic [3:0] BZ_BASE_EXP = 4'h9;
    localparam logic [3:0] SUB_CODE = 4'h8;
    localparam int CNT_W = 13;
endpackage

// ### period_prescaler.sv
`timescale 1ns/1ps
module period_prescaler
    import clock_buzzer_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    input wire logic [3:0] halfExp,
    output logic tick
);
    logic [CNT_W-1:0] cntReg;
    logic [CNT_W-1:0] cntNext;
    logic [CNT_W:0] span;
    logic hit;

    assign span = (CNT_W+1)'(1) << halfExp;
    assign hit = cntReg == CNT_W'(span - (CNT_W+1)'(1));
    assign tick = run && hit;
    assign cntNext = (!run || hit) ? '0 : cntReg + CNT_W'(1);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cntReg <= '0;
        end else begin
            cntReg <= cntNext;
        end
    end
endmodule

// ### square_wave.sv
`timescale 1ns/1ps
module square_wave (
    input wire logic mclk,
    input wire logic rst,
    input wire logic enable,
    input wire logic graceful,
    input wire logic tick,
    output logic running,
    output logic waveReg
);
    logic enPrevReg;
    logic activeReg;
    logic start;
    logic stopNow;

    assign start = enable && !enPrevReg;
    assign stopNow = !enable && (!graceful || !waveReg);
    // Counter restarts on the enabling edge
    assign running = activeReg && !start;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            enPrevReg <= 1'b0;
        end else begin
            enPrevReg <= enable;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            activeReg <= 1'b0;
            waveReg <= 1'b0;
        end else if (start) begin
            activeReg <= 1'b1;
            waveReg <= 1'b0;
        end else if (activeReg && stopNow) begin
            activeReg <= 1'b0;
            waveReg <= 1'b0;
        end else if (activeReg && tick) begin
            waveReg <= !waveReg;
        end
    end
endmodule

// ### clock_buzzer_output.sv
// Function
// - reset clears output select register
// - buzzer enable runs divider, else pin holds its latch bit
// - buzzer divides peripheral clock by 2^10..2^13
// - clock enable runs divider, else pin holds its latch bit
// - source codes 0-7 divide, 8 subclock
// - select register readable, byte and bit writable
// - outputs carry the selected square waves ORed with their latch bits
// - port direction resets to all inputs
// - clock output shortens no high phase except when a prohibited code (9-15) is selected or the clock is re-enabled before the phase ends
`timescale 1ns/1ps
module clock_buzzer_output
    import clock_buzzer_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [15:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic subClockIn,
    output logic programmableClockPinOut,
    output logic programmableClockPinOe,
    output logic buzzerPinOut,
    output logic buzzerPinOe
);
    // ==========================================================
    // Avalon slave
    // ==========================================================
    logic [7:0] cksReg;
    logic [7:0] cksNext;
    logic [7:0] dirReg;
    logic [7:0] latchReg;
    logic waitReg;
    logic [31:0] rdataReg;
    logic request;
    logic firstCycle;
    logic commit;
    logic laneWrite;
    logic selCks;
    logic selDir;
    logic selLatch;
    logic selSet;
    logic selClr;
    logic [7:0] readByte;

    assign request = read || write;
    assign firstCycle = request && waitReg;
    assign commit = write && !waitReg;
    assign laneWrite = commit && byteenable[0];
    assign selCks = address == CKS_OFS;
    assign selDir = address == DIR_OFS;
    assign selLatch = address == LATCH_OFS;
    assign selSet = address == CKS_SET_OFS;
    assign selClr = address == CKS_CLR_OFS;
    // Unmapped addresses read as zero
    assign readByte = selCks ? cksReg :
                      selDir ? dirReg :
                      selLatch ? latchReg : 8'h00;

    // Byte write, or bit set and bit clear aliases
    assign cksNext = !laneWrite ? cksReg :
                     selCks ? writedata[7:0] :
                     selSet ? (cksReg | writedata[7:0]) :
                     selClr ? (cksReg & ~writedata[7:0]) : cksReg;

    assign readdata = rdataReg;
    assign waitrequest = waitReg;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            waitReg <= 1'b1;
            rdataReg <= 32'h0000_0000;
        end else begin
            waitReg <= !firstCycle;
            if (firstCycle) begin
                rdataReg <= {24'h00_0000, readByte};
            end
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cksReg <= CKS_RST;
            dirReg <= DIR_RST;
            latchReg <= LATCH_RST;
        end else begin
            cksReg <= cksNext;
            if (laneWrite && selDir) begin
                dirReg <= writedata[7:0];
            end
            if (laneWrite && selLatch) begin
                latchReg <= writedata[7:0];
            end
        end
    end

    // ==========================================================
    // Subsystem clock synchroniser
    // ==========================================================
    logic subSync1Reg;
    logic subSync2Reg;
    logic subSync3Reg;
    logic subEdge;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            subSync1Reg <= 1'b0;
            subSync2Reg <= 1'b0;
            subSync3Reg <= 1'b0;
        end else begin
            subSync1Reg <= subClockIn;
            subSync2Reg <= subSync1Reg;
            subSync3Reg <= subSync2Reg;
        end
    end

    assign subEdge = subSync2Reg ^ subSync3Reg;

    // ==========================================================
    // Clock output divider
    // ==========================================================
    logic [3:0] clkCode;
    logic srcValid;
    logic clkEnable;
    logic [3:0] clkExp;
    logic clkPreTick;
    logic clkTick;
    logic clkRun;
    logic clkWave;

    assign clkCode = cksReg[CL_SEL_HI:CL_SEL_LO];
    assign srcValid = clkCode <= SUB_CODE;
    assign clkEnable = cksReg[CL_EN_BIT] && srcValid;
    // Undivided code toggles every cycle, the fastest a flop can go
    assign clkExp = (clkCode == 4'h0) ? 4'h0 : clkCode - 4'h1;
    assign clkTick = (clkCode == SUB_CODE) ? subEdge : clkPreTick;

    period_prescaler clk_div (
        .mclk(mclk),
        .rst(rst),
        .run(clkRun),
        .halfExp(clkExp),
        .tick(clkPreTick)
    );

    // Graceful stop finishes the high phase
    square_wave clk_wave (
        .mclk(mclk),
        .rst(rst),
        .enable(clkEnable),
        .graceful(srcValid),
        .tick(clkTick),
        .running(clkRun),
        .waveReg(clkWave)
    );

    // ==========================================================
    // Buzzer divider
    // ==========================================================
    logic [1:0] buzSel;
    logic [3:0] buzExp;
    logic buzTick;
    logic buzRun;
    logic buzWave;

    assign buzSel = cksReg[BZ_SEL_HI:BZ_SEL_LO];
    assign buzExp = BZ_BASE_EXP + {2'b00, buzSel};

    period_prescaler buz_div (
        .mclk(mclk),
        .rst(rst),
        .run(buzRun),
        .halfExp(buzExp),
        .tick(buzTick)
    );

    square_wave buz_wave (
        .mclk(mclk),
        .rst(rst),
        .enable(cksReg[BZ_EN_BIT]),
        .graceful(1'b0),
        .tick(buzTick),
        .running(buzRun),
        .waveReg(buzWave)
    );

    // ==========================================================
    // Pin drivers
    // ==========================================================
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            programmableClockPinOut <= 1'b0;
            programmableClockPinOe <= 1'b0;
            buzzerPinOut <= 1'b0;
            buzzerPinOe <= 1'b0;
        end else begin
            programmableClockPinOut <= latchReg[CLK_PIN_BIT] | clkWave;
            programmableClockPinOe <= !dirReg[CLK_PIN_BIT];
            buzzerPinOut <= latchReg[BUZ_PIN_BIT] | buzWave;
            buzzerPinOe <= !dirReg[BUZ_PIN_BIT];
        end
    end

    // ==========================================================
    // Assertions
    // ==========================================================
    logic buzPrevReg;
    logic buzSeenReg;
    logic [CNT_W-1:0] buzCntReg;
    logic buzToggled;
    logic [CNT_W:0] buzHalf;

    assign buzToggled = buzWave != buzPrevReg;
    assign buzHalf = (CNT_W+1)'(1) << buzExp;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            buzPrevReg <= 1'b0;
            buzSeenReg <= 1'b0;
            buzCntReg <= '0;
        end else begin
            buzPrevReg <= buzWave;
            buzCntReg <= buzToggled ? '0 : buzCntReg + CNT_W'(1);
            if (!cksReg[BZ_EN_BIT]) begin
                buzSeenReg <= 1'b0;
            end else if (buzToggled) begin
                buzSeenReg <= 1'b1;
            end
        end
    end

    property p_reset_select;
        @(posedge mclk) $fell(rst) |-> cksReg == CKS_RST && !clkWave && !buzWave;
    endproperty
    a_reset_select: assert property (p_reset_select) else $error("select not clear after reset");

    property p_reset_dir;
        @(posedge mclk) $fell(rst) |-> dirReg == DIR_RST && !buzzerPinOe;
    endproperty
    a_reset_dir: assert property (p_reset_dir) else $error("direction not all inputs after reset");

    property p_buz_off;
        @(posedge mclk) disable iff (rst)
            !cksReg[BZ_EN_BIT] |=> !buzWave ##1 !buzzerPinOut || latchReg[BUZ_PIN_BIT];
    endproperty
    a_buz_off: assert property (p_buz_off) else $error("buzzer not low when disabled");

    property p_buz_half;
        @(posedge mclk) disable iff (rst)
            cksReg[BZ_EN_BIT] && buzSeenReg && buzToggled |-> buzCntReg == CNT_W'(buzHalf - 1);
    endproperty
    a_buz_half: assert property (p_buz_half) else $error("buzzer half period wrong");

    property p_clk_off;
        @(posedge mclk) disable iff (rst) !cksReg[CL_EN_BIT] && !clkWave |=> !clkWave;
    endproperty
    a_clk_off: assert property (p_clk_off) else $error("clock output rose while disabled");

    property p_sub_follow;
        @(posedge mclk) disable iff (rst)
            clkCode == SUB_CODE && $past(clkCode) == SUB_CODE && $changed(clkWave) && clkWave
            |-> $past(subEdge);
    endproperty
    a_sub_follow: assert property (p_sub_follow) else $error("subclock output moved without edge");

    property p_write_select;
        @(posedge mclk) disable iff (rst)
            write && !waitrequest && selCks && byteenable[0] |=> cksReg == $past(writedata[7:0]);
    endproperty
    a_write_select: assert property (p_write_select) else $error("select write lost");

    property p_no_runt;
        @(posedge mclk) disable iff (rst)
            clkWave && srcValid && $past(srcValid) |=> clkWave || $past(clkTick);
    endproperty
    a_no_runt: assert property (p_no_runt) else $error("clock high phase cut short");

    property p_restart;
        @(posedge mclk) disable iff (rst) $rose(cksReg[BZ_EN_BIT]) |=> !buzWave ##1 !buzWave;
    endproperty
    a_restart: assert property (p_restart) else $error("buzzer did not restart low");

    property p_bad_code;
        @(posedge mclk) disable iff (rst) !srcValid |=> !clkWave;
    endproperty
    a_bad_code: assert property (p_bad_code) else $error("prohibited code drove clock");

    c_buz_toggle: cover property (@(posedge mclk) disable iff (rst) buzSeenReg && buzToggled);
    c_sub_out: cover property (@(posedge mclk) disable iff (rst) clkCode == SUB_CODE && $rose(clkWave));
    c_soft_stop: cover property (@(posedge mclk) disable iff (rst) $fell(cksReg[CL_EN_BIT]) && clkWave);
    c_read: cover property (@(posedge mclk) disable iff (rst) read && !waitrequest && selCks);
endmodule

// ### pin_load_model.sv
`timescale 1ns/1ps
// ========================================
// Load on one output pin, plus a free-running subsystem clock source
module pin_load_model #(
    parameter int SUB_HALF_NS = 300
) (
    input wire logic mclk,
    input wire logic pin,
    output logic subClock,
    output int highLen,
    output int lowLen,
    output int rises
);
    logic prev;
    int run;

    initial begin
        subClock = 1'b0;
        forever #(SUB_HALF_NS) subClock = ~subClock;
    end

    initial begin
        prev = 1'b0;
        run = 0;
        highLen = 0;
        lowLen = 0;
        rises = 0;
    end

    // Length in mclk cycles of the last finished high and low phase
    always @(posedge mclk) begin
        if (pin === prev) begin
            run <= run + 1;
        end else begin
            if (prev === 1'b1) highLen <= run;
            else lowLen <= run;
            if (pin === 1'b1) rises <= rises + 1;
            run <= 1;
        end
        prev <= pin;
    end
endmodule

// ### testbench.sv
`timescale 1ns/1ps
`define CHECK(a, b) begin checked++; if ((a) !== (b)) begin badCount++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench
    import clock_buzzer_pkg::*;
;
    logic mclk, rst, read, write, subClockIn;
    logic [15:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable;
    logic waitrequest, clkOut, clkOe, buzOut, buzOe;
    wire logic clkPin = clkOe ? clkOut : 1'b0;
    wire logic buzPin = buzOe ? buzOut : 1'b0;
    int clkHigh, clkLow, clkRises, buzHigh, buzLow, buzRises;
    int badCount = 0;
    int checked = 0;
    logic [7:0] rd;

    clock_buzzer_output uut (.mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .subClockIn(subClockIn), .programmableClockPinOut(clkOut), .programmableClockPinOe(clkOe),
        .buzzerPinOut(buzOut), .buzzerPinOe(buzOe));
    pin_load_model #(.SUB_HALF_NS(300)) clkLoad (.mclk(mclk), .pin(clkPin), .subClock(subClockIn),
        .highLen(clkHigh), .lowLen(clkLow), .rises(clkRises));
    pin_load_model buzLoad (.mclk(mclk), .pin(buzPin), .subClock(),
        .highLen(buzHigh), .lowLen(buzLow), .rises(buzRises));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ========================================
    // Bus tasks
    task automatic busAccess(input logic [15:0] a, input logic [7:0] d, input logic [3:0] be,
                             input logic isWrite);
        int n;
        @(posedge mclk);
        address <= a;
        writedata <= {24'h000000, d};
        byteenable <= be;
        write <= isWrite;
        read <= ~isWrite;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 100);
        rd = readdata[7:0];
        write <= 1'b0;
        read <= 1'b0;
        if (n >= 100) begin
            badCount++;
            print_verdict();
        end
    endtask

    task automatic readCheck(input logic [15:0] a, input logic [7:0] exp);
        busAccess(a, 8'h00, 4'hF, 1'b0);
        `CHECK(rd, exp)
    endtask

    task automatic waitRises(ref int cnt, input int goal, input int bound);
        int n;
        n = 0;
        while (cnt < goal && n < bound) begin
            @(posedge mclk);
            n++;
        end
        `CHECK(cnt >= goal, 1'b1)
    endtask

    // ========================================
    // Scenarios
    task automatic resetAndRegisters();
        readCheck(CKS_OFS, 8'h00);
        readCheck(DIR_OFS, 8'hFF);
        `CHECK({clkOe, buzOe, clkPin, buzPin}, 4'h0)
        busAccess(CKS_OFS, 8'h0B, 4'hF, 1'b1);
        readCheck(CKS_OFS, 8'h0B);
        busAccess(CKS_SET_OFS, 8'h60, 4'hF, 1'b1);
        readCheck(CKS_OFS, 8'h6B);
        busAccess(CKS_CLR_OFS, 8'h0A, 4'hF, 1'b1);
        readCheck(CKS_OFS, 8'h61);
        busAccess(CKS_OFS, 8'h00, 4'h0, 1'b1);
        readCheck(CKS_OFS, 8'h61);
        busAccess(16'hFF60, 8'h55, 4'hF, 1'b1);
        readCheck(16'hFF60, 8'h00);
        busAccess(CKS_OFS, 8'h00, 4'hF, 1'b1);
        busAccess(DIR_OFS, 8'hFC, 4'hF, 1'b1);
        busAccess(LATCH_OFS, 8'h00, 4'hF, 1'b1);
        readCheck(DIR_OFS, 8'hFC);
        `CHECK({clkOe, buzOe}, 2'h3)
    endtask

    task automatic clockCodes();
        int h;
        // Codes 1 and 2 would put more than 10 MHz on the pin at a 50 MHz peripheral clock
        for (int n = 3; n <= 7; n++) begin
            h = 1 << (n - 1);
            busAccess(CKS_OFS, 8'(n), 4'hF, 1'b1);
            busAccess(CKS_SET_OFS, 8'h10, 4'hF, 1'b1);
            `CHECK(clkPin, 1'b0)
            waitRises(clkRises, clkRises + 2, 8 * h + 20);
            `CHECK(clkHigh, h)
            `CHECK(clkLow, h)
            busAccess(CKS_CLR_OFS, 8'h10, 4'hF, 1'b1);
            repeat (2 * h + 4) @(posedge mclk);
            `CHECK(clkPin, 1'b0)
            `CHECK(clkHigh, h)
        end
    endtask

    task automatic subClockAndProhibited();
        int r;
        busAccess(CKS_OFS, 8'h08, 4'hF, 1'b1);
        busAccess(CKS_SET_OFS, 8'h10, 4'hF, 1'b1);
        waitRises(clkRises, clkRises + 3, 200);
        `CHECK(clkHigh inside {[14:16]}, 1'b1)
        busAccess(CKS_CLR_OFS, 8'h10, 4'hF, 1'b1);
        repeat (40) @(posedge mclk);
        busAccess(CKS_OFS, 8'h09, 4'hF, 1'b1);
        busAccess(CKS_SET_OFS, 8'h10, 4'hF, 1'b1);
        r = clkRises;
        repeat (64) @(posedge mclk);
        `CHECK(clkRises, r)
        `CHECK(clkPin, 1'b0)
        busAccess(CKS_OFS, 8'h00, 4'hF, 1'b1);
    endtask

    task automatic buzzerCodes();
        int h;
        for (int c = 0; c <= 3; c++) begin
            h = 1 << (9 + c);
            busAccess(CKS_OFS, 8'(c << 5), 4'hF, 1'b1);
            busAccess(CKS_SET_OFS, 8'h80, 4'hF, 1'b1);
            waitRises(buzRises, buzRises + 2, 5 * h);
            `CHECK(buzHigh, h)
            `CHECK(buzLow, h)
            busAccess(CKS_CLR_OFS, 8'h80, 4'hF, 1'b1);
            repeat (3) @(posedge mclk);
            `CHECK(buzPin, 1'b0)
        end
    endtask

    task automatic midRunReset();
        busAccess(CKS_OFS, 8'h08, 4'hF, 1'b1);
        busAccess(CKS_SET_OFS, 8'h90, 4'hF, 1'b1);
        repeat (50) @(posedge mclk);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        `CHECK({clkOe, buzOe, clkPin, buzPin}, 4'h0)
        readCheck(CKS_OFS, 8'h00);
        readCheck(DIR_OFS, 8'hFF);
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, badCount);
        if (badCount == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ========================================
    // Main sequence
    initial begin
        rst = 1'b1;
        read = 1'b0;
        write = 1'b0;
        address = 16'h0000;
        writedata = 32'h00000000;
        byteenable = 4'h0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        resetAndRegisters();
        clockCodes();
        subClockAndProhibited();
        buzzerCodes();
        midRunReset();
        print_verdict();
    end
endmodule
